// ---- dv/host_mcu_model.sv ----
// Host model: answers, test requests, reset pull
`timescale 1ns/1ps
module host_mcu_model (
    input wire logic i_ref_clk,
    input wire logic [7:0] i_challenge,
    input wire logic i_mcu_reset_out_n,
    output safety_wd_pkg::cmd_t o_cmd,
    output logic o_mcu_reset_pin
);
    import safety_wd_pkg::*;
    logic ext_rst_r;
    // Wired reset line: low while either side pulls
    assign o_mcu_reset_pin = i_mcu_reset_out_n & ~ext_rst_r;
    initial begin
        o_cmd = '0;
        ext_rst_r = 1'b0;
    end
    // One-cycle answer strobe
    task automatic answer(input logic good);
        @(negedge i_ref_clk);
        o_cmd.ans = good ? ~i_challenge : i_challenge;
        o_cmd.ans_wr = 1'b1;
        @(negedge i_ref_clk);
        o_cmd.ans_wr = 1'b0;
        o_cmd.ans = ~o_cmd.ans; // Stale data must not look valid
    endtask
    // Second self-test request: one-cycle strobe, sent once after power-up
    task automatic req_selftest();
        @(negedge i_ref_clk);
        o_cmd.analog_selftest_second_req = 1'b1;
        @(negedge i_ref_clk);
        o_cmd.analog_selftest_second_req = 1'b0;
    endtask
    // External reset: pull the line for a few cycles
    task automatic ext_reset();
        @(negedge i_ref_clk);
        ext_rst_r = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        ext_rst_r = 1'b0;
    endtask
endmodule

// ---- dv/safety_wd_chk.sv ----
// Concurrent checks on the safety watchdog state machine ports
`timescale 1ns/1ps
module safety_wd_chk #(
    parameter int HALF_MS_CYC = 25000
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire safety_wd_pkg::cmd_t i_cmd,
    input wire logic o_mcu_reset_out_n,
    input wire logic o_failsafe_out_zero_n,
    input wire logic o_failsafe_out_one_n,
    input wire logic o_interrupt_out_n,
    input wire logic o_analog_selftest_second_start,
    input wire logic o_regulators_en,
    input wire logic [7:0] o_challenge_word_reg,
    input wire logic [2:0] o_wd_err_cnt,
    input wire logic [2:0] o_fault_cnt,
    input wire safety_wd_pkg::fsm_state_t o_state
);
    import safety_wd_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);
    // Trip: reset pulled
    sequence trip_s;
        $fell(o_mcu_reset_out_n);
    endsequence
    sequence wd_err_s;
        $fell(o_interrupt_out_n) ##0 (o_state == ST_NORMAL);
    endsequence
    start_cause_a: assert property (o_analog_selftest_second_start |-> $past(i_cmd.analog_selftest_second_req))
        else $error("unrequested self-test");
    start_pulse_a: assert property (o_analog_selftest_second_start |=> !o_analog_selftest_second_start)
        else $error("long start pulse");
    trip_fs_a: assert property (trip_s |-> !o_failsafe_out_zero_n)
        else $error("trip without fs zero");
    fault_step_a: assert property (trip_s ##0 (o_fault_cnt < FLT_FINAL) |=>
        o_fault_cnt == $past(o_fault_cnt) + 3'h1) else $error("fault count stuck");
    wd_step_a: assert property (wd_err_s ##0 (o_wd_err_cnt < 3'h4) |=>
        o_wd_err_cnt == $past(o_wd_err_cnt) + 3'h2) else $error("error step wrong");
    chal_keep_a: assert property (wd_err_s |=> $stable(o_challenge_word_reg))
        else $error("challenge changed");
    fs_follow_a: assert property (!o_failsafe_out_zero_n |=> !o_failsafe_out_one_n)
        else $error("fs one released early");
    rst_release_a: assert property ($rose(o_mcu_reset_out_n) |=>
        (o_state == ST_INIT || o_state == ST_NORMAL)) else $error("reset released in wrong state");
    deep_out_a: assert property (o_state == ST_DEEP_FS |-> !o_mcu_reset_out_n &&
        !o_failsafe_out_zero_n && !o_failsafe_out_one_n && !o_regulators_en)
        else $error("deep outputs released");
    wake_clear_a: assert property (o_state == ST_WAIT_PRE |-> o_fault_cnt == FLT_START &&
        o_challenge_word_reg == CHAL_RESET) else $error("start state not cleared");
    deep_seen_c: cover property (o_state == ST_DEEP_FS);
endmodule

bind safety_window_watchdog_fsm safety_wd_chk #(.HALF_MS_CYC(HALF_MS_CYC)) u_safety_wd_chk (.*);

// ---- dv/tb_top.sv ----
// Self-checking bench for the safety watchdog state machine
`timescale 1ns/1ps
module tb_top;
    import safety_wd_pkg::*;
    logic i_ref_clk, i_nrst, pre_ok, lst_done, ast1_done, ast2_done, ast2_pass;
    logic aux_crit, dfs_en, flt, key, rst_pin, rst_n, fs0_n, fs1_n, int_n, start, regs_en, ka_en;
    logic dbg, ka_on;
    logic [7:0] chal;
    logic [2:0] wd_err, flt_cnt;
    cmd_t cmd;
    fsm_state_t st;
    int error_cnt = 0;
    int comparisons = 0;
    // Short half-ms base keeps windows short
    safety_window_watchdog_fsm #(.HALF_MS_CYC(10)) u_safety_window_watchdog_fsm (
        .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cmd(cmd), .i_preregulator_ok(pre_ok),
        .i_logic_selftest_done(lst_done), .i_analog_selftest_first_done(ast1_done),
        .i_analog_selftest_second_done(ast2_done), .i_analog_selftest_second_pass(ast2_pass),
        .i_aux_supply_critical(aux_crit), .i_deep_fs_enable(dfs_en), .i_keep_alive_supply_on(ka_on),
        .i_supervisor_fault(flt), .i_mcu_reset_pin(rst_pin), .i_key_pin(key), .i_debug_pin(dbg),
        .o_mcu_reset_out_n(rst_n), .o_failsafe_out_zero_n(fs0_n), .o_failsafe_out_one_n(fs1_n),
        .o_interrupt_out_n(int_n), .o_analog_selftest_second_start(start),
        .o_regulators_en(regs_en), .o_keep_alive_supply_en(ka_en), .o_challenge_word_reg(chal),
        .o_wd_err_cnt(wd_err), .o_fault_cnt(flt_cnt), .o_state(st));
    host_mcu_model u_host_mcu_model (.i_ref_clk(i_ref_clk), .i_challenge(chal),
        .i_mcu_reset_out_n(rst_n), .o_cmd(cmd), .o_mcu_reset_pin(rst_pin));
    initial begin
        i_ref_clk = 1'b0;
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    // Expected next challenge
    function automatic logic [7:0] next_chal(input logic [7:0] c);
        next_chal = {c[6:0], ^(c & CHAL_TAPS)};
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Bounded waits; expiry fails
    task automatic wait_st(input fsm_state_t s);
        int n;
        n = 0;
        while (st !== s && n < 600) begin
            @(negedge i_ref_clk);
            n++;
        end
        if (st !== s) begin
            chk("state wait", 32'(st), 32'(s));
            wrap_up();
        end
    endtask
    task automatic wait_int();
        int n;
        n = 0;
        while (int_n !== 1'b0 && n < 100) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("interrupt", 32'(int_n), 32'h0);
        if (int_n !== 1'b0) wrap_up();
    endtask
    task automatic t_reset();
        chk("reset out", 32'(rst_n), 32'h0);
        chk("challenge", 32'(chal), 32'hB2);
        chk("fault count", 32'(flt_cnt), 32'h1);
        chk("state", 32'(st), 32'(ST_WAIT_PRE));
    endtask
    task automatic t_powerup();
        pre_ok = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        chk("reset held", 32'(rst_n), 32'h0);
        lst_done = 1'b1;
        ast1_done = 1'b1;
        wait_st(ST_INIT);
        chk("reset released", 32'(rst_n), 32'h1);
        chk("fail-safe zero", 32'(fs0_n), 32'h0);
    endtask
    task automatic t_analog_selftest_second();
        chk("no self-test", 32'(start), 32'h0);
        u_host_mcu_model.req_selftest();
        chk("self-test start", 32'(start), 32'h1);
        @(negedge i_ref_clk);
        chk("start pulse", 32'(start), 32'h0);
        ast2_done = 1'b1;
        ast2_pass = 1'b1;
        @(negedge i_ref_clk);
        ast2_done = 1'b0;
        chk("fs zero held", 32'(fs0_n), 32'h0);
    endtask
    task automatic t_init_exit();
        u_host_mcu_model.answer(1'b1);
        repeat (2) @(negedge i_ref_clk);
        chk("normal mode", 32'(st), 32'(ST_NORMAL));
        chk("new challenge", 32'(chal), 32'(next_chal(CHAL_RESET)));
    endtask
    // Bad, closed, good, timeout, then a trip
    task automatic t_window();
        logic [7:0] c;
        int n;
        c = chal;
        repeat (44) @(negedge i_ref_clk);
        u_host_mcu_model.answer(1'b0);
        wait_int();
        repeat (2) @(negedge i_ref_clk);
        chk("err after bad", 32'(wd_err), 32'h2);
        chk("challenge kept", 32'(chal), 32'(c));
        repeat (3) @(negedge i_ref_clk);
        u_host_mcu_model.answer(1'b1);
        wait_int();
        repeat (2) @(negedge i_ref_clk);
        chk("err closed write", 32'(wd_err), 32'h4);
        repeat (40) @(negedge i_ref_clk);
        u_host_mcu_model.answer(1'b1);
        repeat (3) @(negedge i_ref_clk);
        chk("err after good", 32'(wd_err), 32'h3);
        chk("challenge step", 32'(chal), 32'(next_chal(c)));
        wait_int();
        repeat (2) @(negedge i_ref_clk);
        chk("err timeout", 32'(wd_err), 32'h5);
        repeat (40) @(negedge i_ref_clk);
        u_host_mcu_model.answer(1'b0);
        repeat (3) @(negedge i_ref_clk);
        chk("trip state", 32'(st), 32'(ST_ASSERT_RST));
        chk("trip fault", 32'(flt_cnt), 32'h2);
        n = 0;
        while (rst_n === 1'b0 && n < 400) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk("reset length", 32'(n >= 185 && n <= 215), 32'h1);
        wait_st(ST_NORMAL);
    endtask
    // Faults into deep fail-safe, key off and on
    task automatic t_deep();
        dfs_en = 1'b1;
        u_host_mcu_model.ext_reset();
        chk("ext reset", 32'(st), 32'(ST_ASSERT_RST));
        chk("ext fault", 32'(flt_cnt), 32'h3);
        for (int k = 4; k <= 6; k++) begin
            wait_st(ST_NORMAL);
            flt = 1'b1;
            @(negedge i_ref_clk);
            flt = 1'b0;
            repeat (3) @(negedge i_ref_clk);
            chk("fault step", 32'(flt_cnt), 32'(k));
        end
        chk("deep state", 32'(st), 32'(ST_DEEP_FS));
        chk("regulators off", 32'({regs_en, ka_en, rst_n, fs0_n, fs1_n}), 32'h08);
        key = 1'b0;
        wait_st(ST_LOW_POWER_OFF_DEEP);
        pre_ok = 1'b0;
        key = 1'b1;
        wait_st(ST_WAIT_PRE);
        chk("wake fault", 32'(flt_cnt), 32'h1);
        chk("wake challenge", 32'(chal), 32'hB2);
    endtask
    initial begin
        i_nrst = 1'b0;
        {pre_ok, lst_done, ast1_done, ast2_done, ast2_pass, dfs_en, flt, dbg} = '0;
        aux_crit = 1'b1;
        ka_on = 1'b1;
        key = 1'b1;
        repeat (2) @(negedge i_ref_clk);
        i_nrst = 1'b1;
        t_reset();
        t_powerup();
        t_analog_selftest_second();
        t_init_exit();
        t_window();
        t_deep();
        wrap_up();
    end
endmodule

// ---- rtl/safety_wd_pkg.sv ----
// Constants and types for the safety watchdog
package safety_wd_pkg;
    // Clock and time base
    localparam int CLK_PERIOD_NS = 20;
    localparam int HALF_MS_NS = 500000;
    localparam int HALF_MS_CYCLES = HALF_MS_NS / CLK_PERIOD_NS;
    localparam int INIT_WINDOW_MS = 256;
    localparam int RST_LOW_LIMIT_MS = 8000;
    localparam logic [11:0] INIT_HALF_TICKS = 12'(INIT_WINDOW_MS * 2);
    localparam logic [13:0] RST_LOW_HALF_TICKS = 14'(RST_LOW_LIMIT_MS * 2);

    // Challenge word
    localparam logic [7:0] CHAL_RESET = 8'hB2;
    localparam logic [7:0] CHAL_TAPS = 8'hB8;

    // Counters
    localparam logic [2:0] WD_ERR_MAX = 3'h6;
    localparam logic [2:0] WD_ERR_STEP = 3'h2;
    localparam logic [2:0] RFR_MAX = 3'h6;
    localparam logic [2:0] FLT_START = 3'h1;
    localparam logic [2:0] FLT_FINAL = 3'h6;

    // Window codes: 0 disables, 1..15 select a period
    localparam logic [3:0] WIN_DISABLED = 4'h0;
    localparam logic [3:0] WIN_DEFAULT = 4'h3;

    typedef enum logic [2:0] {
        ST_WAIT_PRE,
        ST_SELFTEST,
        ST_INIT,
        ST_NORMAL,
        ST_ASSERT_RST,
        ST_DEEP_FS,
        ST_LOW_POWER_OFF_DEEP
    } fsm_state_t;

    // Serial commands, one-cycle strobes
    typedef struct packed {
        logic ans_wr;
        logic [7:0] ans;
        logic seed_wr;
        logic [7:0] seed;
        logic win_wr;
        logic [3:0] win_code;
        logic rdur_wr;
        logic [1:0] rdur;
        logic imp_wr;
        logic timer8_dis;
        logic analog_selftest_second_req;
    } cmd_t;

    // Safety configuration, erased on every wake-up
    typedef struct packed {
        logic [3:0] win_code;
        logic [3:0] win_pend;
        logic pend_valid;
        logic [1:0] rdur;
        logic timer8_dis;
    } cfg_t;

    localparam cfg_t CFG_DEFAULT = '{win_code: WIN_DEFAULT, win_pend: WIN_DEFAULT,
        pend_valid: 1'b0, rdur: 2'h0, timer8_dis: 1'b0};

    // Half period in half-ms ticks
    function automatic logic [11:0] win_half_ticks(input logic [3:0] code);
        case (code)
            4'h1: win_half_ticks = 12'h001;
            4'h2: win_half_ticks = 12'h002;
            4'h3: win_half_ticks = 12'h003;
            4'h4: win_half_ticks = 12'h004;
            4'h5: win_half_ticks = 12'h006;
            4'h6: win_half_ticks = 12'h008;
            4'h7: win_half_ticks = 12'h00C;
            4'h8: win_half_ticks = 12'h010;
            4'h9: win_half_ticks = 12'h018;
            4'hA: win_half_ticks = 12'h020;
            4'hB: win_half_ticks = 12'h040;
            4'hC: win_half_ticks = 12'h080;
            4'hD: win_half_ticks = 12'h100;
            4'hE: win_half_ticks = 12'h200;
            4'hF: win_half_ticks = 12'h400;
            default: win_half_ticks = 12'h003;
        endcase
    endfunction

    // Reset low duration in half-ms ticks
    function automatic logic [11:0] rdur_half_ticks(input logic [1:0] code);
        case (code)
            2'h0: rdur_half_ticks = 12'h014;
            2'h1: rdur_half_ticks = 12'h002;
            2'h2: rdur_half_ticks = 12'h064;
            default: rdur_half_ticks = 12'h0C8;
        endcase
    endfunction

    // Expected answer: the host computes the same transform
    function automatic logic [7:0] answer_of(input logic [7:0] chal);
        answer_of = ~chal;
    endfunction
endpackage

// ---- rtl/safety_window_watchdog_fsm.sv ----
// Fail-safe state machine with challenge/response window watchdog
// What this block does
// - Second analog self-test only on host command
// - Critical aux supply holds fail-safe zero until test
// - Init phase starts when reset output releases after the self-tests
// - Init lasts 256 ms, then init fields lock
// - First good answer moves init to normal
// - Any reset-causing fault leaves normal mode
// - Reset held for configured duration, then released
// - Deep fail-safe on final count or 8 s
// - Deep fail-safe: outputs asserted, key controls exit
// - Power-up 8 s timer until reset release
// - 8 s timer restarts per assertion, disableable
// - Missing or closed-window answer is an error
// - Debug pin at start-up inhibits watchdog effect
// - Fifteen selectable window periods, default 3 ms
// - Watchdog disable allowed only in init phase
// - Eight-bit LFSR challenge, host seed optional
// - Challenge resets to B2 hex
// - Good answer: new challenge, window restarts
// - Wrong answer: error count, restart, interrupt
// - Failed init answer: reset, fail-safe, fault count
// - New period applies at answer or timeout
// - Failure adds two, good refresh subtracts one
// - Fault count starts at one, fail-safe asserted
`timescale 1ns/1ps
module safety_window_watchdog_fsm #(
    parameter int HALF_MS_CYC = safety_wd_pkg::HALF_MS_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire safety_wd_pkg::cmd_t i_cmd,
    input wire logic i_preregulator_ok,
    input wire logic i_logic_selftest_done,
    input wire logic i_analog_selftest_first_done,
    input wire logic i_analog_selftest_second_done,
    input wire logic i_analog_selftest_second_pass,
    input wire logic i_aux_supply_critical,
    input wire logic i_deep_fs_enable,
    input wire logic i_keep_alive_supply_on,
    input wire logic i_supervisor_fault,
    input wire logic i_mcu_reset_pin,
    input wire logic i_key_pin,
    input wire logic i_debug_pin,
    output logic o_mcu_reset_out_n,
    output logic o_failsafe_out_zero_n,
    output logic o_failsafe_out_one_n,
    output logic o_interrupt_out_n,
    output logic o_analog_selftest_second_start,
    output logic o_regulators_en,
    output logic o_keep_alive_supply_en,
    output logic [7:0] o_challenge_word_reg,
    output logic [2:0] o_wd_err_cnt,
    output logic [2:0] o_fault_cnt,
    output safety_wd_pkg::fsm_state_t o_state
);
    import safety_wd_pkg::*;

    fsm_state_t state_r;
    cfg_t cfg_r;
    logic [7:0] chal_r;
    logic [2:0] wd_err_r;
    logic [2:0] rfr_r;
    logic [2:0] flt_r;
    logic analog_selftest_second_ok_r;
    logic wd_en_r;
    logic dbg_r;
    logic [11:0] rcnt_r;
    logic [13:0] t8_r;
    logic [2:0] rst_sync_r, key_sync_r, dbg_sync_r;
    logic [1:0] rst_echo_r;
    logic tick, closed, timeout;

    // Three-stage synchronisers for pins; only stage two is read
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_r <= 3'h7;
            key_sync_r <= 3'h0;
            dbg_sync_r <= 3'h0;
            rst_echo_r <= 2'h0;
        end else begin
            rst_echo_r <= {rst_echo_r[0], o_mcu_reset_out_n}; // Own drive, synchroniser delay
            rst_sync_r <= {rst_sync_r[1:0], i_mcu_reset_pin};
            key_sync_r <= {key_sync_r[1:0], i_key_pin};
            dbg_sync_r <= {dbg_sync_r[1:0], i_debug_pin};
        end
    end

    wire rst_pin = rst_sync_r[1];
    wire key_pin = key_sync_r[1];
    wire dbg_pin = dbg_sync_r[1];

    // Phase decode
    wire in_init = (state_r == ST_INIT);
    wire in_norm = (state_r == ST_NORMAL);
    wire wd_act = (in_init || in_norm) && wd_en_r;
    wire selftests_done = i_logic_selftest_done && i_analog_selftest_first_done;
    wire wake = (state_r == ST_LOW_POWER_OFF_DEEP) && key_pin;

    // Answer classification
    wire ans_good = (i_cmd.ans == answer_of(chal_r));
    wire wd_ok = wd_act && i_cmd.ans_wr && ans_good && !closed;
    wire wd_nok = wd_act && ((i_cmd.ans_wr && (!ans_good || closed)) || timeout);
    wire init_fail = in_init && wd_nok;
    wire init_idle_end = in_init && !wd_en_r && timeout;
    wire [2:0] err_sum = 3'(wd_err_r + WD_ERR_STEP);
    wire err_max = in_norm && wd_nok && (err_sum >= WD_ERR_MAX);

    // External reset: line pulled low while this block releases it
    wire ext_rst = (in_init || in_norm) && rst_echo_r[1] && !rst_pin;
    wire trip = (in_init || in_norm) && (i_supervisor_fault || ext_rst
        || ((init_fail || err_max) && !dbg_r));
    wire [2:0] flt_inc = (flt_r == FLT_FINAL) ? flt_r : 3'(flt_r + 3'h1);
    wire dfs_go_cnt = i_deep_fs_enable && trip && (flt_inc == FLT_FINAL);
    wire t8_run = (state_r == ST_WAIT_PRE) || (state_r == ST_SELFTEST)
        || ((state_r == ST_ASSERT_RST) && !cfg_r.timer8_dis);
    wire dfs_go_t8 = i_deep_fs_enable && t8_run && (t8_r >= RST_LOW_HALF_TICKS);
    wire rst_done = (state_r == ST_ASSERT_RST) && (rcnt_r >= rdur_half_ticks(cfg_r.rdur))
        && !i_supervisor_fault;
    wire refresh_apply = i_cmd.ans_wr || timeout;
    wire win_wr_ok = i_cmd.win_wr && (in_init || (in_norm && i_cmd.win_code != WIN_DISABLED));

    // Main state sequence
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= ST_WAIT_PRE;
        end else begin
            case (state_r)
                ST_WAIT_PRE:
                    if (dfs_go_t8) state_r <= ST_DEEP_FS;
                    else if (i_preregulator_ok) state_r <= ST_SELFTEST;
                ST_SELFTEST:
                    if (dfs_go_t8) state_r <= ST_DEEP_FS;
                    else if (selftests_done) state_r <= ST_INIT;
                ST_INIT:
                    if (dfs_go_cnt) state_r <= ST_DEEP_FS;
                    else if (trip) state_r <= ST_ASSERT_RST;
                    else if (wd_ok || init_idle_end || init_fail) state_r <= ST_NORMAL;
                ST_NORMAL:
                    if (dfs_go_cnt) state_r <= ST_DEEP_FS;
                    else if (trip) state_r <= ST_ASSERT_RST;
                ST_ASSERT_RST:
                    if (dfs_go_t8) state_r <= ST_DEEP_FS;
                    else if (rst_done) state_r <= ST_NORMAL;
                ST_DEEP_FS:
                    if (!key_pin) state_r <= ST_LOW_POWER_OFF_DEEP;
                ST_LOW_POWER_OFF_DEEP:
                    if (key_pin) state_r <= ST_WAIT_PRE;
                default: state_r <= ST_WAIT_PRE;
            endcase
        end
    end

    // Debug level caught at start-up
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dbg_r <= 1'b0;
        end else if (state_r == ST_SELFTEST && selftests_done) begin
            dbg_r <= dbg_pin;
        end
    end

    // Safety configuration; init-only fields lock when init is left
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cfg_r <= CFG_DEFAULT;
            wd_en_r <= 1'b1;
        end else if (wake) begin
            cfg_r <= CFG_DEFAULT; // Config is lost in low-power off
            wd_en_r <= 1'b1;
        end else begin
            if (in_init && i_cmd.rdur_wr) cfg_r.rdur <= i_cmd.rdur;
            if (in_init && i_cmd.imp_wr) cfg_r.timer8_dis <= i_cmd.timer8_dis;
            if (win_wr_ok && (!wd_en_r || i_cmd.win_code == WIN_DISABLED)) begin
                cfg_r.win_code <= i_cmd.win_code;
                cfg_r.pend_valid <= 1'b0;
                wd_en_r <= (i_cmd.win_code != WIN_DISABLED);
            end else if (win_wr_ok) begin
                cfg_r.win_pend <= i_cmd.win_code;
                cfg_r.pend_valid <= 1'b1;
            end else if (cfg_r.pend_valid && refresh_apply) begin
                cfg_r.win_code <= cfg_r.win_pend;
                cfg_r.pend_valid <= 1'b0;
            end
        end
    end

    // Window timer: init is one fully open span, normal is closed then open
    window_period_reg_timer #(
        .HALF_MS_CYC(HALF_MS_CYC)
    ) u_timer (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_run(in_init || (in_norm && wd_en_r)),
        .i_restart(i_cmd.ans_wr && wd_act),
        .i_fully_open(in_init),
        .i_half_ticks(win_half_ticks(cfg_r.win_code)),
        .o_tick(tick),
        .o_closed(closed),
        .o_timeout(timeout)
    );

    // Challenge word: seed in init, advance only on a good answer
    wire lfsr_fb = ^(chal_r & CHAL_TAPS);
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            chal_r <= CHAL_RESET;
        end else if (wake) begin
            chal_r <= CHAL_RESET;
        end else if (wd_ok) begin
            chal_r <= {chal_r[6:0], lfsr_fb};
        end else if (in_init && i_cmd.seed_wr) begin
            chal_r <= i_cmd.seed;
        end
    end

    // Watchdog error and refresh counters
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wd_err_r <= 3'h0;
            rfr_r <= 3'h0;
        end else if (wake || err_max) begin
            wd_err_r <= 3'h0;
            rfr_r <= 3'h0;
        end else if (wd_nok) begin
            wd_err_r <= err_sum;
            rfr_r <= 3'h0;
        end else if (wd_ok) begin
            wd_err_r <= (wd_err_r == 3'h0) ? 3'h0 : 3'(wd_err_r - 3'h1);
            rfr_r <= (rfr_r == RFR_MAX) ? 3'h0 : 3'(rfr_r + 3'h1);
        end
    end

    // Fault error counter: up on each trip until FLT_FINAL, down after a run of refreshes
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            flt_r <= FLT_START;
        end else if (wake) begin
            flt_r <= FLT_START;
        end else if (trip) begin
            flt_r <= flt_inc;
        end else if (wd_ok && rfr_r == RFR_MAX && flt_r != 3'h0) begin
            flt_r <= 3'(flt_r - 3'h1);
        end
    end

    // Second analog self-test: started by command only, result held
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            analog_selftest_second_ok_r <= 1'b0;
            o_analog_selftest_second_start <= 1'b0;
        end else begin
            o_analog_selftest_second_start <= i_cmd.analog_selftest_second_req && (in_init || in_norm);
            if (wake) analog_selftest_second_ok_r <= 1'b0;
            else if (i_analog_selftest_second_done) analog_selftest_second_ok_r <= i_analog_selftest_second_pass;
        end
    end

    // Reset duration and 8 s reset-low timers on the half-ms tick
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rcnt_r <= 12'h000;
            t8_r <= 14'h0000;
        end else begin
            if (state_r != ST_ASSERT_RST) rcnt_r <= 12'h000;
            else if (tick) rcnt_r <= 12'(rcnt_r + 12'h001);
            if (trip || !t8_run) t8_r <= 14'h0000;
            else if (tick && t8_r != RST_LOW_HALF_TICKS) t8_r <= 14'(t8_r + 14'h0001);
        end
    end

    // Output pins, all registered; fail-safe zero waits for the aux test
    wire fs_ok_state = in_init || in_norm || (state_r == ST_ASSERT_RST);
    wire aux_gate = !i_aux_supply_critical || analog_selftest_second_ok_r;
    wire fs0_rel = fs_ok_state && (flt_r == 3'h0) && aux_gate;
    wire deep = (state_r == ST_DEEP_FS) || (state_r == ST_LOW_POWER_OFF_DEEP);
    wire rst_rel = (in_init && !trip) || (in_norm && !trip) || rst_done
        || (state_r == ST_SELFTEST && selftests_done);
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mcu_reset_out_n <= 1'b0;
            o_failsafe_out_zero_n <= 1'b0;
            o_failsafe_out_one_n <= 1'b0;
            o_interrupt_out_n <= 1'b1;
            o_regulators_en <= 1'b0;
            o_keep_alive_supply_en <= 1'b0;
        end else begin
            o_mcu_reset_out_n <= rst_rel && !deep && !dfs_go_cnt && !dfs_go_t8;
            o_failsafe_out_zero_n <= fs0_rel && !trip;
            o_failsafe_out_one_n <= o_failsafe_out_zero_n && fs0_rel && !trip;
            o_interrupt_out_n <= !wd_nok;
            o_regulators_en <= !deep && !dfs_go_cnt && !dfs_go_t8
                && (state_r != ST_WAIT_PRE || i_preregulator_ok);
            o_keep_alive_supply_en <= i_keep_alive_supply_on && (state_r != ST_LOW_POWER_OFF_DEEP
                || o_keep_alive_supply_en);
        end
    end

    // Status mirrors
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_challenge_word_reg <= CHAL_RESET;
            o_wd_err_cnt <= 3'h0;
            o_fault_cnt <= FLT_START;
            o_state <= ST_WAIT_PRE;
        end else begin
            o_challenge_word_reg <= chal_r;
            o_wd_err_cnt <= wd_err_r;
            o_fault_cnt <= flt_r;
            o_state <= state_r;
        end
    end
endmodule

// ---- rtl/window_period_reg_timer.sv ----
// Half-ms time base and closed/open window timer for the watchdog
`timescale 1ns/1ps
module window_period_reg_timer #(
    parameter int HALF_MS_CYC = safety_wd_pkg::HALF_MS_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_run,
    input wire logic i_restart,
    input wire logic i_fully_open,
    input wire logic [11:0] i_half_ticks,
    output logic o_tick,
    output logic o_closed,
    output logic o_timeout
);
    import safety_wd_pkg::*;

    logic [15:0] pre_r;
    logic [11:0] wcnt_r;
    logic tick_r;

    // Window length: closed half then open half, or one open init span
    wire [11:0] total = i_fully_open ? INIT_HALF_TICKS : 12'(i_half_ticks << 1);
    wire pre_wrap = (pre_r == 16'(HALF_MS_CYC - 1));
    wire win_end = tick_r && (wcnt_r == 12'(total - 12'h001));

    // Half-ms prescaler, realigned on restart
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pre_r <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            pre_r <= (pre_wrap || i_restart) ? 16'h0000 : 16'(pre_r + 16'h0001);
            tick_r <= pre_wrap && !i_restart;
        end
    end

    // Window position; a timeout wraps back into the closed half
    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wcnt_r <= 12'h000;
        end else if (!i_run || i_restart || win_end) begin
            wcnt_r <= 12'h000;
        end else if (tick_r) begin
            wcnt_r <= 12'(wcnt_r + 12'h001);
        end
    end

    assign o_tick = tick_r;
    assign o_timeout = i_run && win_end && !i_restart;
    assign o_closed = i_run && !i_fully_open && (wcnt_r < i_half_ticks);
endmodule
